// >>> test_station_digital_io_bench.sv
// Self-checking bench for the digital I/O block
`timescale 1ns/1ps
module test_station_digital_io_bench;
    logic               clk_sys = 1'b0;
    logic               srst = 1'b1;
    logic               hsel = 1'b0;
    logic [31:0]        haddr = 32'h0;
    logic [1:0]         htrans = 2'h0;
    logic [2:0]         hsize = 3'h0;
    logic               hwrite = 1'b0;
    logic [31:0]        hwdata = 32'h0;
    logic [31:0]        hrdata;
    logic               hreadyout, hresp, go = 1'b0, keep = 1'b1;
    tsd_pkg::tsd_word_s val = '0;
    tsd_pkg::tsd_word_s inWord, outWord;
    logic               inStrobe, outStrobeN, resetOut, settleDone, trigOut;
    logic               sweepGate, lateGate, chanSelect;
    logic [7:0]         portA, portB, portC;
    logic [6:0]         sig;
    int                 num_errors = 0;
    int                 n_checks = 0;

    always #2 clk_sys = ~clk_sys;
    assign sig = {sweepGate, !lateGate, !sweepGate, trigOut, settleDone, resetOut, !outStrobeN};

    tsd_top #(.RATE0_CYC(20), .RATE1_CYC(30), .RATE2_CYC(40), .RATE3_CYC(50),
              .US_CYC(4)) i_dut (
        .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .inWord(inWord),
        .inStrobe(inStrobe), .outWord(outWord), .outStrobeN(outStrobeN),
        .resetOut(resetOut), .settleDone(settleDone), .trigOut(trigOut),
        .sweepGate(sweepGate), .lateGate(lateGate), .chanSelect(chanSelect),
        .portA(portA), .portB(portB), .portC(portC));
    tsd_src i_src (.clk_sys(clk_sys), .go(go), .keep(keep), .val(val),
                   .inWord(inWord), .inStrobe(inStrobe));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (num_errors == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Bounded wait on the bus ready, or on one watched output going high
    task automatic waitfor(input int s, output int n);
        n = 0;
        while (((s < 0) ? hreadyout : sig[s]) !== 1'b1 || (s < 0 && n == 0)) begin
            @(posedge clk_sys);
            n++;
            if (n > 400) begin
                num_errors++;
                test_done();
            end
        end
    endtask : waitfor

    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                        output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        waitfor(-1, n);
        htrans <= 2'h0;
        hwdata <= d;
        waitfor(-1, n);
        r = hrdata;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(r, e);
    endtask : rc

    // Count high cycles and rising edges of one watched output
    task automatic meas(input int s, input int w, output int hi, output int ups);
        logic p;
        hi = 0;
        ups = 0;
        p = sig[s];
        repeat (w) begin
            @(posedge clk_sys);
            hi += sig[s];
            ups += (sig[s] && !p);
            p = sig[s];
        end
    endtask : meas

    task automatic present(input tsd_pkg::tsd_word_s v);
        val <= v;
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (24) @(posedge clk_sys);
    endtask : present

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] c0, r;
        int hi, ups, n;
        logic [31:0] oVal [6] = '{32'h5, 32'hffffffff, 32'h1fffff, 32'd123456,
                                  32'hfffffc25, 32'd250000};
        logic [21:0] oExp [6] = '{22'h5, 22'h3fffff, 22'h1fffff, 22'h123456,
                                  22'h200987, 22'h199999};
        logic [21:0] iIn [4] = '{22'h3ffffb, 22'h100000, 22'h123456, 22'h200042};
        logic [31:0] iExp [4] = '{32'hfffffffb, 32'h100000, 32'h1e240, 32'hffffffd6};
        logic [31:0] iSc [4] = '{32'hfffffff1, 32'h300000, 32'h5a6c0, 32'hffffff82};
        repeat (4) @(posedge clk_sys);
        chk({portA, portB, portC, chanSelect, sweepGate, lateGate, outStrobeN}, 28'h7);
        srst <= 1'b0;
        meas(1, 40, hi, ups);
        chk(hi, 25);
        rc(8'h08, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(8'h00, (i > 2) ? 32'h2 : 32'h0);
            wr(8'h10, oVal[i]);
            meas(0, 40, hi, ups);
            chk(hi, 25);
            chk(ups, 1);
            chk(outWord, oExp[i]);
            rc(8'h10, oVal[i]);
        end
        for (int i = 0; i < 3; i++) begin
            wr(8'h18, 32'h1 << i);
            meas(i + 1, 40, hi, ups);
            chk(hi, 25);
            chk(ups, 1);
        end
        wr(8'h08, 32'h3);
        keep <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, (i > 1) ? 32'h5 : 32'h4);
            xfer(8'h2c, 1'b0, 32'h0, c0);
            present(iIn[i]);
            rc(8'h04, iExp[i]);
            rc(8'h0c, iSc[i]);
            rc(8'h2c, {14'h0, 2'b11, c0[15:0] + 16'h1});
        end
        wr(8'h00, 32'h0);
        keep <= 1'b1;
        present('{1'b0, 21'h7});
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, k << 3);
            xfer(8'h2c, 1'b0, 32'h0, c0);
            repeat (600) @(posedge clk_sys);
            xfer(8'h2c, 1'b0, 32'h0, r);
            n = r[15:0] - c0[15:0];
            chk(n == 600 / (20 + 10 * k) || n == 600 / (20 + 10 * k) + 1, 1);
        end
        rc(8'h04, 32'h7);
        wr(8'h1c, 32'h2);
        wr(8'h14, 32'h3);
        waitfor(4, n);
        waitfor(5, n);
        chk(n >= 7 && n <= 9, 1);
        chk(chanSelect, 1'b1);
        wr(8'h18, 32'h8);
        meas(6, 300, hi, ups);
        chk(hi, 250);
        chk(ups, 1);
        wr(8'h14, 32'h0);
        repeat (3) @(posedge clk_sys);
        chk({sweepGate, lateGate, chanSelect}, 3'b110);
        wr(8'h20, 32'h81);
        wr(8'h24, 32'h42);
        wr(8'h28, 32'h3c);
        repeat (2) @(posedge clk_sys);
        chk({portA, portB, portC}, 24'h81423c);
        rc(8'h24, 32'h42);
        wr(8'h40, 32'hffffffff);
        rc(8'h40, 32'h0);
        test_done();
    end
endmodule : test_station_digital_io_bench

// >>> tsd_params.svh
// Constants for the test station digital I/O block
`ifndef TSD_PARAMS_SVH
`define TSD_PARAMS_SVH

`define TSD_MAG_W        21
`define TSD_DIG_W        4
`define TSD_BCD_MAX      32'd199999
`define TSD_CLK_NS       4
`define TSD_CLK_MHZ      250
`define TSD_CLK_HZ       250000000

`define TSD_PULSE_NS     100
`define TSD_PULSE_CYC    ((`TSD_PULSE_NS + `TSD_CLK_NS - 1) / `TSD_CLK_NS)
`define TSD_GAP_NS       1000
`define TSD_GAP_CYC      ((`TSD_GAP_NS + `TSD_CLK_NS - 1) / `TSD_CLK_NS)

`define TSD_RATE0_HZ     1
`define TSD_RATE1_HZ     5
`define TSD_RATE2_HZ     25
`define TSD_RATE3_HZ     100

`define TSD_OFF_CTRL     8'h00
`define TSD_OFF_INVAL    8'h04
`define TSD_OFF_SCALE    8'h08
`define TSD_OFF_SCALED   8'h0c
`define TSD_OFF_OUTVAL   8'h10
`define TSD_OFF_PROG     8'h14
`define TSD_OFF_EVENT    8'h18
`define TSD_OFF_LAG      8'h1c
`define TSD_OFF_PORTA    8'h20
`define TSD_OFF_PORTB    8'h24
`define TSD_OFF_PORTC    8'h28
`define TSD_OFF_STATUS   8'h2c

`define TSD_CTRL_INBCD   0
`define TSD_CTRL_OUTBCD  1
`define TSD_CTRL_EXT     2
`define TSD_CTRL_RATE_LO 3
`define TSD_CTRL_RATE_HI 4
`define TSD_PROG_RUN     0
`define TSD_PROG_CHB     1
`define TSD_EV_RESTORE   0
`define TSD_EV_SETTLE    1
`define TSD_EV_TRIG      2
`define TSD_EV_INNER     3

`define TSD_HTRANS_NSEQ  2'h2
`define TSD_HTRANS_SEQ   2'h3

`endif

// >>> tsd_pkg.sv
// Types shared by the test station digital I/O block
package tsd_pkg;

    typedef struct packed {
        logic        sign;
        logic [20:0] mag;
    } tsd_word_s;

    typedef struct packed {
        logic [1:0] rate;
        logic       extMode;
        logic       outBcd;
        logic       inBcd;
    } tsd_ctrl_s;

    typedef enum logic [1:0] {
        SWP_IDLE,
        SWP_RUN,
        SWP_GAP
    } tsd_sweep_e;

endpackage : tsd_pkg

// >>> tsd_pulse.sv
// Fixed-width pulse generator with registered output
`timescale 1ns/1ps
module tsd_pulse #(
    parameter int WIDTH      = 1,
    parameter bit ACTIVE_LOW = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic srst,
    input  wire logic fire,
    output logic      pulse
);
    logic [15:0] cnt_q;
    logic        busy;

    assign busy = (cnt_q != 16'h0000);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cnt_q <= 16'h0000;
            pulse <= ACTIVE_LOW;
        end else begin
            if (fire) begin
                cnt_q <= 16'(WIDTH);
            end else if (busy) begin
                cnt_q <= cnt_q - 16'h0001;
            end
            pulse <= ACTIVE_LOW ^ (fire | (cnt_q > 16'h0001));
        end
    end
endmodule : tsd_pulse

// >>> tsd_src.sv
// Model of the external word source on the parallel input port
`timescale 1ns/1ps
module tsd_src (
    input  wire logic               clk_sys,
    input  wire logic               go,
    input  wire logic               keep,
    input  wire tsd_pkg::tsd_word_s val,
    output tsd_pkg::tsd_word_s      inWord,
    output logic                    inStrobe
);
    int step = 0;

    initial begin
        inWord = '0;
        inStrobe = 1'b0;
    end

    // Word first, data-good pulse of four cycles starting three cycles later, word inverted after hold when keep is low
    always @(posedge clk_sys) begin
        if (go && step == 0) begin
            inWord <= val;
            step <= 1;
        end else if (step != 0) begin
            step <= (step == 16) ? 0 : step + 1;
            inStrobe <= (step >= 3 && step < 7);
            if (step == 14 && !keep) begin
                inWord <= ~inWord;
            end
        end
    end
endmodule : tsd_src

// >>> tsd_top.sv
// Digital input, output, program control and control ports with AHB-Lite registers
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "tsd_params.svh"
module tsd_top #(
    parameter int RATE0_CYC = `TSD_CLK_HZ / `TSD_RATE0_HZ,
    parameter int RATE1_CYC = `TSD_CLK_HZ / `TSD_RATE1_HZ,
    parameter int RATE2_CYC = `TSD_CLK_HZ / `TSD_RATE2_HZ,
    parameter int RATE3_CYC = `TSD_CLK_HZ / `TSD_RATE3_HZ,
    parameter int US_CYC    = `TSD_CLK_MHZ,
    parameter int PULSE_CYC = `TSD_PULSE_CYC,
    parameter int GAP_CYC   = `TSD_GAP_CYC
) (
    input  wire logic             clk_sys,
    input  wire logic             srst,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic      [31:0]      hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire tsd_pkg::tsd_word_s inWord,
    input  wire logic             inStrobe,
    output tsd_pkg::tsd_word_s    outWord,
    output logic                  outStrobeN,
    output logic                  resetOut,
    output logic                  settleDone,
    output logic                  trigOut,
    output logic                  sweepGate,
    output logic                  lateGate,
    output logic                  chanSelect,
    output logic      [7:0]       portA,
    output logic      [7:0]       portB,
    output logic      [7:0]       portC
);

    ////////////////////////////////////////////////////////////////////////////
    // Conversion helpers

    function automatic logic [31:0] bcd2bin(input logic [20:0] bcd);
        logic [31:0] acc;
        acc = {31'h0, bcd[20]};
        for (int i = 4; i >= 0; i--) begin
            acc = acc * 32'd10 + {28'h0, bcd[i*`TSD_DIG_W +: `TSD_DIG_W]};
        end
        return acc;
    endfunction : bcd2bin

    function automatic logic [20:0] bin2bcd(input logic [31:0] bin);
        logic [23:0] bcd;
        bcd = 24'h0;
        for (int i = 20; i >= 0; i--) begin
            for (int d = 0; d < 6; d++) begin
                if (bcd[d*4 +: 4] > 4'h4) begin
                    bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
                end
            end
            bcd = {bcd[22:0], bin[i]};
        end
        return bcd[20:0];
    endfunction : bin2bcd

    ////////////////////////////////////////////////////////////////////////////
    // Register bus slave

    tsd_pkg::tsd_ctrl_s ctrl_q;
    logic [31:0] inVal_q;
    logic [15:0] scale_q;
    logic [31:0] scaled_q;
    logic [31:0] outVal_q;
    logic [1:0]  prog_q;
    logic [31:0] lag_q;
    logic [15:0] capCnt_q;
    logic [7:0]  wrAddr_q;
    logic [7:0]  rdAddr_q;
    logic        wrPend_q;
    logic        rdPend_q;
    logic [31:0] rdMux;

    wire addrTaken = hsel & hready & (htrans == `TSD_HTRANS_NSEQ | htrans == `TSD_HTRANS_SEQ);
    wire wrTaken   = addrTaken & hwrite;
    wire rdTaken   = addrTaken & ~hwrite;
    wire wrCtrl    = wrPend_q & (wrAddr_q == `TSD_OFF_CTRL);
    wire wrScale   = wrPend_q & (wrAddr_q == `TSD_OFF_SCALE);
    wire wrOut     = wrPend_q & (wrAddr_q == `TSD_OFF_OUTVAL);
    wire wrProg    = wrPend_q & (wrAddr_q == `TSD_OFF_PROG);
    wire wrEvent   = wrPend_q & (wrAddr_q == `TSD_OFF_EVENT);
    wire wrLag     = wrPend_q & (wrAddr_q == `TSD_OFF_LAG);
    wire wrPortA   = wrPend_q & (wrAddr_q == `TSD_OFF_PORTA);
    wire wrPortB   = wrPend_q & (wrAddr_q == `TSD_OFF_PORTB);
    wire wrPortC   = wrPend_q & (wrAddr_q == `TSD_OFF_PORTC);
    wire evRestore = wrEvent & hwdata[`TSD_EV_RESTORE];
    wire evSettle  = wrEvent & hwdata[`TSD_EV_SETTLE];
    wire evTrig    = wrEvent & hwdata[`TSD_EV_TRIG];
    wire evInner   = wrEvent & hwdata[`TSD_EV_INNER];

    always_comb begin
        case (rdAddr_q)
            `TSD_OFF_CTRL:   rdMux = {27'h0, ctrl_q};
            `TSD_OFF_INVAL:  rdMux = inVal_q;
            `TSD_OFF_SCALE:  rdMux = {16'h0, scale_q};
            `TSD_OFF_SCALED: rdMux = scaled_q;
            `TSD_OFF_OUTVAL: rdMux = outVal_q;
            `TSD_OFF_PROG:   rdMux = {30'h0, prog_q};
            `TSD_OFF_LAG:    rdMux = lag_q;
            `TSD_OFF_PORTA:  rdMux = {24'h0, portA};
            `TSD_OFF_PORTB:  rdMux = {24'h0, portB};
            `TSD_OFF_PORTC:  rdMux = {24'h0, portC};
            `TSD_OFF_STATUS: rdMux = {14'h0, lateGate, sweepGate, capCnt_q};
            default:         rdMux = 32'h0;
        endcase
    end

    // Reads take one wait state so a write just before is already visible
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wrPend_q  <= 1'b0;
            rdPend_q  <= 1'b0;
            wrAddr_q  <= 8'h00;
            rdAddr_q  <= 8'h00;
            hrdata    <= 32'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wrPend_q  <= wrTaken;
            rdPend_q  <= rdTaken;
            hreadyout <= ~rdTaken;
            if (wrTaken) begin
                wrAddr_q <= haddr[7:0];
            end
            if (rdTaken) begin
                rdAddr_q <= haddr[7:0];
            end
            if (rdPend_q) begin
                hrdata <= rdMux;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_q   <= '0;
            scale_q  <= 16'h0001;
            outVal_q <= 32'h0;
            prog_q   <= 2'h0;
            lag_q    <= 32'h0;
            portA    <= 8'h00;
            portB    <= 8'h00;
            portC    <= 8'h00;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= hwdata[`TSD_CTRL_RATE_HI:`TSD_CTRL_INBCD];
            end
            if (wrScale) begin
                scale_q <= hwdata[15:0];
            end
            if (wrOut) begin
                outVal_q <= hwdata;
            end
            if (wrProg) begin
                prog_q <= hwdata[`TSD_PROG_CHB:`TSD_PROG_RUN];
            end
            if (wrLag) begin
                lag_q <= hwdata;
            end
            if (wrPortA) begin
                portA <= hwdata[7:0];
            end
            if (wrPortB) begin
                portB <= hwdata[7:0];
            end
            if (wrPortC) begin
                portC <= hwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parallel input capture

    tsd_pkg::tsd_word_s inSync1_q;
    tsd_pkg::tsd_word_s inSync2_q;
    logic        stbSync1_q;
    logic        stbSync2_q;
    logic        stbPrev_q;
    logic [31:0] rateCnt_q;
    logic [31:0] ratePeriod;
    logic [31:0] inDecoded;
    logic [31:0] bcdMag;

    assign bcdMag = bcd2bin(inSync2_q.mag);
    assign inDecoded = ctrl_q.inBcd ? (inSync2_q.sign ? -bcdMag : bcdMag)
                                    : {{11{inSync2_q.sign}}, inSync2_q.mag};

    always_comb begin
        case (ctrl_q.rate)
            2'h0:    ratePeriod = 32'(RATE0_CYC);
            2'h1:    ratePeriod = 32'(RATE1_CYC);
            2'h2:    ratePeriod = 32'(RATE2_CYC);
            default: ratePeriod = 32'(RATE3_CYC);
        endcase
    end

    wire rateHit = (rateCnt_q >= ratePeriod - 32'h1);
    wire extHit  = stbSync2_q & ~stbPrev_q;
    wire capture = ctrl_q.extMode ? extHit : rateHit;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            inSync1_q  <= '0;
            inSync2_q  <= '0;
            stbSync1_q <= 1'b0;
            stbSync2_q <= 1'b0;
            stbPrev_q  <= 1'b0;
            rateCnt_q  <= 32'h0;
            inVal_q    <= 32'h0;
            scaled_q   <= 32'h0;
            capCnt_q   <= 16'h0;
        end else begin
            inSync1_q  <= inWord;
            inSync2_q  <= inSync1_q;
            stbSync1_q <= inStrobe;
            stbSync2_q <= stbSync1_q;
            stbPrev_q  <= stbSync2_q;
            rateCnt_q  <= (rateHit | ctrl_q.extMode) ? 32'h0 : rateCnt_q + 32'h1;
            if (capture) begin
                inVal_q  <= inDecoded;
                capCnt_q <= capCnt_q + 16'h1;
            end
            scaled_q <= 32'($signed(inVal_q) * $signed(scale_q));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parallel output word and strobe

    logic [31:0] outAbs;
    logic [31:0] outClip;
    logic        stbReq_q;
    logic        stbReq2_q;

    assign outAbs  = outVal_q[31] ? -outVal_q : outVal_q;
    assign outClip = (outAbs > `TSD_BCD_MAX) ? `TSD_BCD_MAX : outAbs;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            outWord   <= '0;
            stbReq_q  <= 1'b0;
            stbReq2_q <= 1'b0;
        end else begin
            outWord.sign <= outVal_q[31];
            outWord.mag  <= ctrl_q.outBcd ? bin2bcd(outClip)
                                          : outVal_q[20:0];
            stbReq_q  <= wrOut;
            stbReq2_q <= stbReq_q;
        end
    end

    tsd_pulse #(.WIDTH(PULSE_CYC), .ACTIVE_LOW(1'b1)) uStrobe (
        .clk_sys (clk_sys),
        .srst    (srst),
        .fire    (stbReq2_q),
        .pulse   (outStrobeN)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Program control pulses

    logic powerUp_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            powerUp_q <= 1'b1;
        end else begin
            powerUp_q <= 1'b0;
        end
    end

    tsd_pulse #(.WIDTH(PULSE_CYC), .ACTIVE_LOW(1'b0)) uReset (
        .clk_sys (clk_sys),
        .srst    (srst),
        .fire    (powerUp_q | evRestore),
        .pulse   (resetOut)
    );

    tsd_pulse #(.WIDTH(PULSE_CYC), .ACTIVE_LOW(1'b0)) uSettle (
        .clk_sys (clk_sys),
        .srst    (srst),
        .fire    (evSettle),
        .pulse   (settleDone)
    );

    tsd_pulse #(.WIDTH(PULSE_CYC), .ACTIVE_LOW(1'b0)) uTrig (
        .clk_sys (clk_sys),
        .srst    (srst),
        .fire    (evTrig),
        .pulse   (trigOut)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Sweep gates and channel select

    tsd_pkg::tsd_sweep_e swp_q;
    tsd_pkg::tsd_sweep_e swp_d;
    logic [15:0] gapCnt_q;
    logic [15:0] usCnt_q;
    logic [31:0] lagCnt_q;
    logic        runPrev_q;

    wire runOn    = prog_q[`TSD_PROG_RUN];
    wire gapDone  = (gapCnt_q >= 16'(GAP_CYC - 1));
    wire usTick   = (usCnt_q >= 16'(US_CYC - 1));
    wire lagDone  = (lagCnt_q >= lag_q);
    wire runStart = runOn & ~runPrev_q;

    always_comb begin
        swp_d = swp_q;
        case (swp_q)
            tsd_pkg::SWP_IDLE: begin
                if (runOn) begin
                    swp_d = tsd_pkg::SWP_RUN;
                end
            end
            tsd_pkg::SWP_RUN: begin
                if (!runOn) begin
                    swp_d = tsd_pkg::SWP_IDLE;
                end else if (evInner) begin
                    swp_d = tsd_pkg::SWP_GAP;
                end
            end
            tsd_pkg::SWP_GAP: begin
                if (!runOn) begin
                    swp_d = tsd_pkg::SWP_IDLE;
                end else if (gapDone) begin
                    swp_d = tsd_pkg::SWP_RUN;
                end
            end
            default: swp_d = tsd_pkg::SWP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            swp_q      <= tsd_pkg::SWP_IDLE;
            gapCnt_q   <= 16'h0;
            usCnt_q    <= 16'h0;
            lagCnt_q   <= 32'h0;
            runPrev_q  <= 1'b0;
            sweepGate  <= 1'b1;
            lateGate   <= 1'b1;
            chanSelect <= 1'b0;
        end else begin
            swp_q     <= swp_d;
            runPrev_q <= runOn;
            gapCnt_q  <= (swp_q == tsd_pkg::SWP_GAP) ? gapCnt_q + 16'h1 : 16'h0;
            usCnt_q   <= (usTick | runStart) ? 16'h0 : usCnt_q + 16'h1;
            if (runStart) begin
                lagCnt_q <= 32'h0;
            end else if (usTick & ~lagDone) begin
                lagCnt_q <= lagCnt_q + 32'h1;
            end
            sweepGate  <= ~(swp_d == tsd_pkg::SWP_RUN);
            lateGate   <= ~(swp_d == tsd_pkg::SWP_RUN & lagDone & ~runStart);
            chanSelect <= prog_q[`TSD_PROG_CHB];
        end
    end

endmodule : tsd_top

// >>> tsd_top_chk.sv
// Bus answer, pulse width and gate checks on the top ports
`timescale 1ns/1ps
`include "tsd_params.svh"
module tsd_top_chk #(
    parameter int PULSE_CYC = 25
) (
    input wire logic               clk_sys,
    input wire logic               srst,
    input wire logic               hsel,
    input wire logic [31:0]        haddr,
    input wire logic [1:0]         htrans,
    input wire logic               hwrite,
    input wire logic               hready,
    input wire logic               hreadyout,
    input wire logic               hresp,
    input wire tsd_pkg::tsd_word_s outWord,
    input wire logic               outStrobeN,
    input wire logic               resetOut,
    input wire logic               settleDone,
    input wire logic               trigOut,
    input wire logic               sweepGate,
    input wire logic               lateGate
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    logic [3:0] act;
    logic [7:0] cnt_q [4];

    assign act = {trigOut, settleDone, resetOut, !outStrobeN};

    // Length of the running active phase of each pulse output
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            cnt_q[i] <= (srst || !act[i]) ? 8'h00 : cnt_q[i] + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_rdAns;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_rdWait;
        hsel && hready && htrans[1] && !hwrite |=> s_rdAns;
    endproperty
    property p_wrNoWait;
        hsel && hready && htrans[1] && hwrite |=> hreadyout;
    endproperty
    property p_okay;
        hresp == 1'b0;
    endproperty
    // A format change alters outWord without a strobe, so key on the OUTVAL write
    property p_strobeAfter;
        hsel && hready && htrans[1] && hwrite && (haddr[7:0] == `TSD_OFF_OUTVAL)
            |-> ##4 !outStrobeN;
    endproperty
    property p_strobeLen;
        $rose(outStrobeN) |-> cnt_q[0] == PULSE_CYC;
    endproperty
    property p_powerUp;
        $fell(srst) |-> ##[1:3] resetOut;
    endproperty
    property p_resetLen;
        $fell(resetOut) |-> cnt_q[1] == PULSE_CYC;
    endproperty
    property p_settleLen;
        $fell(settleDone) |-> cnt_q[2] == PULSE_CYC;
    endproperty
    property p_trigLen;
        $fell(trigOut) |-> cnt_q[3] == PULSE_CYC;
    endproperty
    property p_lateFall;
        $fell(lateGate) |-> !sweepGate;
    endproperty

    a_rdWait: assert property (p_rdWait) else $error("read answer timing wrong");
    a_wrNoWait: assert property (p_wrNoWait) else $error("write stalled");
    a_okay: assert property (p_okay) else $error("response not okay");
    a_strobeAfter: assert property (p_strobeAfter) else $error("no strobe");
    a_strobeLen: assert property (p_strobeLen) else $error("strobe width");
    a_powerUp: assert property (p_powerUp) else $error("no reset pulse");
    a_resetLen: assert property (p_resetLen) else $error("reset width");
    a_settleLen: assert property (p_settleLen) else $error("settle width");
    a_trigLen: assert property (p_trigLen) else $error("trigger width");
    a_lateFall: assert property (p_lateFall) else $error("late gate early");
endmodule : tsd_top_chk

bind tsd_top tsd_top_chk #(.PULSE_CYC(PULSE_CYC)) i_chk (
    .clk_sys(clk_sys), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .outWord(outWord),
    .outStrobeN(outStrobeN), .resetOut(resetOut), .settleDone(settleDone),
    .trigOut(trigOut), .sweepGate(sweepGate), .lateGate(lateGate));
